// file: hdl/ccs_host.sv
// clock source switch controller: apb slave that sequences the device clock registers
// Contract
// - main crystal running and stable before select
// - external main enabled before main select
// - internal oscillator may halt after leaving it
// - internal oscillator running before returning to it
// - sub crystal configured and stable before select
// - external sub clock enabled before select
// - internal oscillator may halt on sub clock
// - sub to internal needs running osc, status 0
// - sub to crystal needs stable osc, status 1
// - sub to external main needs status 1
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "ccs_defs.svh"
module ccs_host
  import ccs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output ccs_dev_req_t dev_req,
  input wire logic dev_ack,
  input wire logic [7:0] dev_rdata
);
  // ************************************************************
  // step table
  // ************************************************************
  function automatic ccs_step_t st(input ccs_op_t op, input logic [2:0] idx, input logic [2:0] pos,
                                   input logic val);
    st = '{op: op, idx: idx, pos: pos, val: val};
  endfunction

  function automatic ccs_step_t step_f(input logic [2:0] tgt, input logic [3:0] n, input logic amp,
                                       input logic [2:0] halts);
    ccs_step_t s;
    logic is_main;
    logic is_sub;
    s = st(CCS_OP_NOP, 3'h0, 3'h0, 1'b0);
    is_main = (tgt == CCS_TGT_X1) || (tgt == CCS_TGT_EXTM);
    is_sub = (tgt == CCS_TGT_XT) || (tgt == CCS_TGT_EXTS);
    if (n == 4'hC) begin
      if (halts[0] && tgt != CCS_TGT_IRC) begin
        s = st(CCS_OP_SET, `CCS_DEV_RCM, `CCS_BIT_IRC_HALT, 1'b1);
      end
    end else if (n == 4'hD) begin
      if (halts[1] && !is_main) begin
        s = st(CCS_OP_SET, `CCS_DEV_MOC, `CCS_BIT_MAIN_HALT, 1'b1);
      end
    end else if (n == 4'hE) begin
      if (halts[2] && !is_sub) begin
        s = st(CCS_OP_SET, `CCS_DEV_CLOCK_OP_MODE_REG, `CCS_BIT_SUB_PIN, 1'b0);
      end
    end else if (n == 4'hF) begin
      s = st(CCS_OP_END, 3'h0, 3'h0, 1'b0);
    end else if (tgt == CCS_TGT_IRC) begin
      case (n)
        4'h0: s = st(CCS_OP_SET, `CCS_DEV_RCM, `CCS_BIT_IRC_HALT, 1'b0);
        4'h1: s = st(CCS_OP_POLL, `CCS_DEV_RCM, `CCS_BIT_IRC_STABLE, 1'b1);
        4'h2: s = st(CCS_OP_SET, `CCS_DEV_MCM, `CCS_BIT_MAIN_SEL, 1'b0);
        4'h3: s = st(CCS_OP_POLL, `CCS_DEV_MCM, `CCS_BIT_MAIN_STATUS, 1'b0);
        4'h4: s = st(CCS_OP_SET, `CCS_DEV_PCC, `CCS_BIT_CPU_SUB, 1'b0);
        default: s = st(CCS_OP_NOP, 3'h0, 3'h0, 1'b0);
      endcase
    end else if (is_main) begin
      case (n)
        4'h0: s = st(CCS_OP_SET, `CCS_DEV_CLOCK_OP_MODE_REG, `CCS_BIT_EXT_MAIN, tgt == CCS_TGT_EXTM);
        4'h1: s = st(CCS_OP_SET, `CCS_DEV_CLOCK_OP_MODE_REG, `CCS_BIT_MAIN_PIN, 1'b1);
        4'h2: s = st(CCS_OP_SET, `CCS_DEV_CLOCK_OP_MODE_REG, `CCS_BIT_AMP, amp);
        // the device stalls the cpu by itself; we only wait it out before the next access
        4'h3: s = !amp ? st(CCS_OP_NOP, 3'h0, 3'h0, 1'b0) :
                  (tgt == CCS_TGT_X1) ? st(CCS_OP_HOLDX, 3'h0, 3'h0, 1'b0) :
                  st(CCS_OP_HOLDE, 3'h0, 3'h0, 1'b0);
        4'h4: s = st(CCS_OP_SET, `CCS_DEV_MOC, `CCS_BIT_MAIN_HALT, 1'b0);
        4'h5: s = (tgt == CCS_TGT_X1) ? st(CCS_OP_STAB, 3'h0, 3'h0, 1'b0) :
                  st(CCS_OP_NOP, 3'h0, 3'h0, 1'b0);
        4'h6: s = st(CCS_OP_SET, `CCS_DEV_MCM, `CCS_BIT_MAIN_SEL, 1'b1);
        4'h7: s = st(CCS_OP_POLL, `CCS_DEV_MCM, `CCS_BIT_MAIN_STATUS, 1'b1);
        4'h8: s = st(CCS_OP_SET, `CCS_DEV_PCC, `CCS_BIT_CPU_SUB, 1'b0);
        default: s = st(CCS_OP_NOP, 3'h0, 3'h0, 1'b0);
      endcase
    end else if (is_sub) begin
      case (n)
        4'h0: s = st(CCS_OP_SET, `CCS_DEV_SUBST, `CCS_BIT_SUB_START, 1'b0);
        4'h1: s = st(CCS_OP_SET, `CCS_DEV_CLOCK_OP_MODE_REG, `CCS_BIT_EXT_SUB, tgt == CCS_TGT_EXTS);
        4'h2: s = st(CCS_OP_SET, `CCS_DEV_CLOCK_OP_MODE_REG, `CCS_BIT_SUB_PIN, 1'b1);
        4'h3: s = (tgt == CCS_TGT_XT) ? st(CCS_OP_STAB, 3'h0, 3'h0, 1'b0) :
                  st(CCS_OP_NOP, 3'h0, 3'h0, 1'b0);
        4'h4: s = st(CCS_OP_SET, `CCS_DEV_PCC, `CCS_BIT_CPU_SUB, 1'b1);
        default: s = st(CCS_OP_NOP, 3'h0, 3'h0, 1'b0);
      endcase
    end
    step_f = s;
  endfunction

  // ************************************************************
  // apb slave
  // ************************************************************
  logic [2:0] tgt_reg;
  logic amp_reg;
  logic [2:0] halts_reg;
  logic [15:0] stab_reg;
  logic [2:0] cur_reg;
  ccs_state_t state_reg;
  logic [3:0] n_reg;
  logic [15:0] cnt_reg;
  logic [2:0] pos_reg;
  logic val_reg;
  logic is_set_reg;

  wire logic acc = psel && penable;
  wire logic hit_ctrl = (paddr == `CCS_APB_CTRL);
  wire logic hit_stat = (paddr == `CCS_APB_STAT);
  wire logic hit_stab = (paddr == `CCS_APB_STAB);
  wire logic unmapped = !(hit_ctrl || hit_stat || hit_stab);
  wire logic wr_fire = acc && pready && pwrite;
  wire logic busy = (state_reg != CCS_S_IDLE);
  wire logic [2:0] go_tgt = pwdata[`CCS_CTRL_TGT_LSB +: 3];
  // an order naming no source, or arriving while busy, is dropped
  wire logic go = wr_fire && hit_ctrl && pwdata[`CCS_CTRL_GO] && !busy && (go_tgt <= CCS_TGT_EXTS);
  wire logic [31:0] ctrl_view = {24'h0, halts_reg, amp_reg, tgt_reg, 1'b0};
  wire logic [31:0] stat_view = {24'h0, n_reg, cur_reg, busy};
  wire logic [31:0] rd_mux = hit_ctrl ? ctrl_view : hit_stat ? stat_view : hit_stab ? {16'h0, stab_reg} : 32'h0;

  // one wait state keeps every bus output on a flip-flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      prdata <= (acc && !pready && !pwrite) ? rd_mux : 32'h0;
      pslverr <= acc && !pready && unmapped;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_reg <= 3'h0;
      amp_reg <= 1'b0;
      halts_reg <= 3'h0;
      stab_reg <= `CCS_STAB_RESET;
    end else if (wr_fire && !busy) begin
      if (hit_ctrl) begin
        tgt_reg <= go_tgt;
        amp_reg <= pwdata[`CCS_CTRL_AMP];
        halts_reg <= pwdata[`CCS_CTRL_HALT_SUB:`CCS_CTRL_HALT_IRC];
      end
      if (hit_stab) begin
        stab_reg <= pwdata[15:0];
      end
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  wire ccs_step_t step = step_f(tgt_reg, n_reg, amp_reg, halts_reg);
  wire logic [7:0] bit_mask = 8'h01 << pos_reg;
  wire logic [7:0] rmw_data = val_reg ? (dev_rdata | bit_mask) : (dev_rdata & ~bit_mask);
  wire logic poll_ok = (dev_rdata[pos_reg] == val_reg);
  wire logic [15:0] hold_x1 = 16'(`CCS_HOLD_X1_CYC - 1);
  wire logic [15:0] hold_ext = 16'(`CCS_HOLD_EXT_CYC - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CCS_S_IDLE;
      n_reg <= 4'h0;
      cnt_reg <= 16'h0;
      pos_reg <= 3'h0;
      val_reg <= 1'b0;
      is_set_reg <= 1'b0;
      cur_reg <= 3'h0;
      dev_req <= '0;
    end else begin
      case (state_reg)
        CCS_S_IDLE: begin
          if (go) begin
            n_reg <= 4'h0;
            state_reg <= CCS_S_FETCH;
          end
        end
        CCS_S_FETCH: begin
          pos_reg <= step.pos;
          val_reg <= step.val;
          is_set_reg <= (step.op == CCS_OP_SET);
          case (step.op)
            CCS_OP_SET, CCS_OP_POLL: begin
              dev_req <= '{valid: 1'b1, write: 1'b0, addr: step.idx, wdata: 8'h00};
              state_reg <= CCS_S_RD;
            end
            CCS_OP_STAB: begin
              cnt_reg <= stab_reg;
              state_reg <= CCS_S_WAIT;
            end
            CCS_OP_HOLDX: begin
              cnt_reg <= hold_x1;
              state_reg <= CCS_S_WAIT;
            end
            CCS_OP_HOLDE: begin
              cnt_reg <= hold_ext;
              state_reg <= CCS_S_WAIT;
            end
            CCS_OP_END: begin
              cur_reg <= tgt_reg;
              state_reg <= CCS_S_IDLE;
            end
            default: n_reg <= n_reg + 4'h1;
          endcase
        end
        CCS_S_RD: begin
          if (dev_ack) begin
            if (is_set_reg) begin
              dev_req <= '{valid: 1'b1, write: 1'b1, addr: dev_req.addr, wdata: rmw_data};
              state_reg <= CCS_S_WR;
            end else begin
              // a poll that misses simply reads again; there is no timeout
              dev_req <= '0;
              n_reg <= poll_ok ? n_reg + 4'h1 : n_reg;
              state_reg <= CCS_S_FETCH;
            end
          end
        end
        CCS_S_WR: begin
          if (dev_ack) begin
            dev_req <= '0;
            n_reg <= n_reg + 4'h1;
            state_reg <= CCS_S_FETCH;
          end
        end
        CCS_S_WAIT: begin
          if (cnt_reg == 16'h0) begin
            n_reg <= n_reg + 4'h1;
            state_reg <= CCS_S_FETCH;
          end else begin
            cnt_reg <= cnt_reg - 16'h1;
          end
        end
        default: state_reg <= CCS_S_IDLE;
      endcase
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_pready_one: assert property (@(posedge clk) disable iff (!rst_n)
    acc && !pready |=> pready) else $error("apb answer not after one wait");
  a_pready_drop: assert property (@(posedge clk) disable iff (!rst_n)
    pready |=> !pready) else $error("pready stood two cycles");
  a_req_held: assert property (@(posedge clk) disable iff (!rst_n)
    dev_req.valid && !dev_ack |=> $stable(dev_req)) else $error("device request changed before ack");
  a_rmw_order: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == CCS_S_WR |-> dev_req.write && dev_req.addr == $past(dev_req.addr)) else $error("write lost address");
  a_irc_halt_guard: assert property (@(posedge clk) disable iff (!rst_n)
    dev_req.valid && dev_req.write && dev_req.addr == `CCS_DEV_RCM && dev_req.wdata[0] |-> tgt_reg != CCS_TGT_IRC)
    else $error("internal oscillator halted while selected");
  a_hold_x1_len: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == CCS_S_FETCH && step.op == CCS_OP_HOLDX |=> cnt_reg == 16'(`CCS_HOLD_X1_CYC - 1))
    else $error("crystal hold wait wrong length");
  a_hold_ext_len: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == CCS_S_FETCH && step.op == CCS_OP_HOLDE |=> cnt_reg == 16'(`CCS_HOLD_EXT_CYC - 1))
    else $error("external hold wait wrong length");
  a_wait_ends: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == CCS_S_WAIT && cnt_reg == 16'h0 |=> state_reg == CCS_S_FETCH && n_reg == $past(n_reg) + 4'h1)
    else $error("sequence did not resume after wait");
  a_go_busy: assert property (@(posedge clk) disable iff (!rst_n)
    go |=> busy) else $error("accepted order did not start");
  a_unmapped_err: assert property (@(posedge clk) disable iff (!rst_n)
    acc && !pready && unmapped |=> pslverr) else $error("unmapped access without error");
  a_prdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !pready |-> prdata == 32'h0)
    else $error("read data outside the answer cycle");
  a_err_with_ready: assert property (@(posedge clk) disable iff (!rst_n)
    pslverr |-> pready)
    else $error("error without ready");
  // tail halts must never touch the clock that the cpu has just been moved to
  a_main_halt_guard: assert property (@(posedge clk) disable iff (!rst_n)
    dev_req.valid && dev_req.write && dev_req.addr == `CCS_DEV_MOC && dev_req.wdata[`CCS_BIT_MAIN_HALT]
    |-> tgt_reg != CCS_TGT_X1 && tgt_reg != CCS_TGT_EXTM)
    else $error("main clock halted while selected");
  a_sub_stop_guard: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == CCS_S_WR && dev_req.addr == `CCS_DEV_CLOCK_OP_MODE_REG && pos_reg == `CCS_BIT_SUB_PIN && !val_reg
    |-> tgt_reg != CCS_TGT_XT && tgt_reg != CCS_TGT_EXTS)
    else $error("sub clock stopped while selected");
  a_wait_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == CCS_S_WAIT |-> !dev_req.valid)
    else $error("device accessed during a wait");
endmodule

// file: hdl/ccs_defs.svh
// offsets, field positions, reset values and timing counts of the clock source switch controller
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH
// ************************************************************
// apb register map of the controller
// ************************************************************
`define CCS_APB_CTRL 12'h000
`define CCS_APB_STAT 12'h004
`define CCS_APB_STAB 12'h008
`define CCS_CTRL_GO 0
`define CCS_CTRL_TGT_LSB 1
`define CCS_CTRL_AMP 4
`define CCS_CTRL_HALT_IRC 5
`define CCS_CTRL_HALT_MAIN 6
`define CCS_CTRL_HALT_SUB 7
`define CCS_STAB_RESET 16'h0FA0
// ************************************************************
// device register indices and bit positions
// ************************************************************
`define CCS_DEV_MCM 3'h0
`define CCS_DEV_PCC 3'h1
`define CCS_DEV_RCM 3'h2
`define CCS_DEV_CLOCK_OP_MODE_REG 3'h3
`define CCS_DEV_MOC 3'h4
`define CCS_DEV_SUBST 3'h5
`define CCS_BIT_MAIN_SEL 3'h0
`define CCS_BIT_MAIN_STATUS 3'h1
`define CCS_BIT_CPU_SUB 3'h4
`define CCS_BIT_IRC_HALT 3'h0
`define CCS_BIT_IRC_STABLE 3'h7
`define CCS_BIT_EXT_MAIN 3'h7
`define CCS_BIT_MAIN_PIN 3'h6
`define CCS_BIT_EXT_SUB 3'h5
`define CCS_BIT_SUB_PIN 3'h4
`define CCS_BIT_AMP 3'h0
`define CCS_BIT_MAIN_HALT 3'h7
`define CCS_BIT_SUB_START 3'h0
// ************************************************************
// timing
// ************************************************************
`define CCS_CLK_NS 50
`define CCS_HOLD_X1_NS 16120
`define CCS_HOLD_X1_CYC ((`CCS_HOLD_X1_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)
`define CCS_EXT_HOLD_CLKS 160
`define CCS_EXT_MIN_KHZ 1000
`define CCS_HOLD_EXT_NS (`CCS_EXT_HOLD_CLKS * 1000000 / `CCS_EXT_MIN_KHZ)
`define CCS_HOLD_EXT_CYC ((`CCS_HOLD_EXT_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)
`endif

// file: hdl/ccs_pkg.sv
// types of the clock source switch controller
package ccs_pkg;
  typedef enum logic [2:0] {
    CCS_TGT_IRC = 3'h0,
    CCS_TGT_X1 = 3'h1,
    CCS_TGT_EXTM = 3'h2,
    CCS_TGT_XT = 3'h3,
    CCS_TGT_EXTS = 3'h4
  } ccs_tgt_t;
  typedef enum logic [2:0] {
    CCS_OP_NOP = 3'h0,
    CCS_OP_SET = 3'h1,
    CCS_OP_POLL = 3'h2,
    CCS_OP_STAB = 3'h3,
    CCS_OP_HOLDX = 3'h4,
    CCS_OP_HOLDE = 3'h5,
    CCS_OP_END = 3'h6
  } ccs_op_t;
  typedef struct packed {
    ccs_op_t op;
    logic [2:0] idx;
    logic [2:0] pos;
    logic val;
  } ccs_step_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ccs_dev_req_t;
  typedef enum logic [2:0] {
    CCS_S_IDLE = 3'h0,
    CCS_S_FETCH = 3'h1,
    CCS_S_RD = 3'h2,
    CCS_S_WR = 3'h3,
    CCS_S_WAIT = 3'h4
  } ccs_state_t;
endpackage

// file: tb/ccs_dev_model.sv
// device clock register model answering the controller's register link
`timescale 1ns/1ps
module ccs_dev_model
  import ccs_pkg::*;
(
  input ccs_dev_req_t dev_req,
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  output logic dev_ack,
  output logic [7:0] dev_rdata
);
  logic [7:0] regs [0:5];
  logic gap_reg;
  logic [2:0] wait_reg;
  logic [12:0] hold_reg;
  logic main_off;
  logic sub_off;
  logic cpu_held;
  // ************************************************************
  // clock gates
  // ************************************************************
  assign main_off = regs[4][7];
  assign sub_off = !regs[3][4];
  assign cpu_held = hold_reg != 13'h0;
  // ************************************************************
  // register link
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 6; i++) regs[i] <= (i == 2 || i == 4) ? 8'h80 : 8'h00;
      dev_ack <= 1'b0;
      gap_reg <= 1'b0;
      wait_reg <= 3'h0;
      hold_reg <= 13'h0;
      dev_rdata <= 8'h00;
    end else begin
      dev_ack <= 1'b0;
      gap_reg <= dev_ack;
      // a released data bus inverts every bit each cycle, so the last value read shows again every other cycle
      dev_rdata <= ~dev_rdata;
      if (cpu_held) hold_reg <= hold_reg - 13'h1;
      if (dev_req.valid && !dev_ack && !gap_reg) begin
        if (wait_reg != 3'h0) begin
          wait_reg <= wait_reg - 3'h1;
        end else begin
          dev_ack <= 1'b1;
          wait_reg <= slow ? 3'h5 : 3'h0;
          dev_rdata <= regs[dev_req.addr];
          if (dev_req.write) begin
            regs[dev_req.addr] <= dev_req.wdata;
            if (dev_req.addr == 3'h3 && dev_req.wdata[0] && !regs[3][0]) begin
              hold_reg <= regs[3][7] ? 13'hC80 : 13'h143;
            end
          end
        end
      end
      // status bits are read-only and follow their controls one cycle late
      regs[0][1] <= regs[0][0];
      regs[2][7] <= !regs[2][0];
    end
  end
endmodule

// file: tb/testbench.sv
// self-checking testbench of the clock source switch controller
`timescale 1ns/1ps
`include "ccs_defs.svh"
module testbench import ccs_pkg::*;;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ccs_dev_req_t dev_req;
  logic dev_ack;
  logic [7:0] dev_rdata;
  logic slow;
  logic [31:0] seed;
  logic [5:0] exp_st;
  logic [5:0] dev_bits;
  logic [2:0] cur_t;
  logic [3:0] exp_idx;
  int error_cnt;
  int total_checks;
  int cyc;
  ccs_host i_ccs_host (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dev_req(dev_req), .dev_ack(dev_ack), .dev_rdata(dev_rdata));
  ccs_dev_model i_ccs_dev_model (.dev_req(dev_req), .clk(clk), .rst_n(rst_n), .slow(slow),
    .dev_ack(dev_ack), .dev_rdata(dev_rdata));
  assign dev_bits = {i_ccs_dev_model.regs[1][4], i_ccs_dev_model.regs[0][0], i_ccs_dev_model.regs[2][0],
    i_ccs_dev_model.main_off, !i_ccs_dev_model.sub_off, i_ccs_dev_model.regs[3][7]};
  // the controller must leave the device alone until the cpu clock hold is over
  always @(posedge clk) begin
    if (rst_n && dev_req.valid && !dev_ack) begin
      chk("cpu held on access", 32'h0, {31'h0, i_ccs_dev_model.cpu_held});
    end
  end
  // ************************************************************
  // clock, timeout and helpers
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // bits: cpu sub select, main select, osc halt, main halt, sub pin mode, ext main select
  function automatic logic [5:0] next_st(input logic [5:0] s, input logic [2:0] t, input logic [2:0] h);
    logic [5:0] n;
    n[5] = t >= 3'h3;
    n[4] = (t == 3'h0) ? 1'b0 : (t <= 3'h2) ? 1'b1 : s[4];
    n[3] = (h[0] && t != 3'h0) ? 1'b1 : (t == 3'h0) ? 1'b0 : s[3];
    n[2] = (t == 3'h1 || t == 3'h2) ? 1'b0 : h[1] ? 1'b1 : s[2];
    n[1] = (t >= 3'h3) ? 1'b1 : h[2] ? 1'b0 : s[1];
    n[0] = (t == 3'h1) ? 1'b0 : (t == 3'h2) ? 1'b1 : s[0];
    return n;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic switch_to(input logic [2:0] t, input logic amp, input logic [2:0] h, input logic poke,
    output int dur);
    int t0;
    logic [31:0] rd;
    logic er;
    t0 = cyc;
    apb(1'b1, `CCS_APB_CTRL, {24'h0, h, amp, t, 1'b1}, rd, er);
    if (poke) begin
      apb(1'b1, `CCS_APB_STAB, 32'h9, rd, er);
      apb(1'b1, `CCS_APB_CTRL, 32'h1, rd, er);
    end
    do apb(1'b0, `CCS_APB_STAT, 32'h0, rd, er); while (rd[0] === 1'b1);
    dur = cyc - t0;
    if (t <= 3'h4) begin
      cur_t = t;
      exp_idx = 4'hF;
      exp_st = next_st(exp_st, t, h);
    end
    chk("stat target", {24'h0, exp_idx, cur_t, 1'b0}, {24'h0, rd[7:0]});
    chk("device bits", {26'h0, exp_st}, {26'h0, dev_bits});
    apb(1'b0, `CCS_APB_CTRL, 32'h0, rd, er);
    chk("ctrl readback", {24'h0, h, amp, t, 1'b0}, rd);
    chk("ctrl error", 32'h0, {31'h0, er});
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [31:0] rd;
    logic er;
    int dur;
    {psel, penable, pwrite, paddr, pwdata, slow} = '0;
    {error_cnt, total_checks, cyc} = '0;
    seed = 32'hAB2D;
    exp_st = 6'h04;
    cur_t = 3'h0;
    exp_idx = 4'h0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `CCS_APB_STAB, 32'h0, rd, er);
    chk("stab reset", 32'h0FA0, rd);
    apb(1'b0, `CCS_APB_STAT, 32'h0, rd, er);
    chk("stat reset", 32'h0, rd);
    apb(1'b0, 12'h00C, 32'h0, rd, er);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, `CCS_APB_STAB, 32'h4, rd, er);
    switch_to(3'h5, 1'b0, 3'h0, 1'b0, dur);
    switch_to(3'h1, 1'b1, 3'h1, 1'b0, dur);
    chk("crystal hold", 32'h1, {31'h0, dur >= 323});
    chk("amp bit", 32'h1, {31'h0, i_ccs_dev_model.regs[3][0]});
    switch_to(3'h3, 1'b0, 3'h3, 1'b0, dur);
    switch_to(3'h2, 1'b1, 3'h0, 1'b1, dur);
    chk("ext hold", 32'h1, {31'h0, dur >= 3200});
    apb(1'b0, `CCS_APB_STAB, 32'h0, rd, er);
    chk("stab kept", 32'h4, rd);
    switch_to(3'h0, 1'b0, 3'h4, 1'b0, dur);
    switch_to(3'h4, 1'b0, 3'h1, 1'b0, dur);
    switch_to(3'h1, 1'b0, 3'h4, 1'b0, dur);
    repeat (14) begin
      seed = xs(seed);
      slow <= seed[3];
      switch_to(3'(seed[6:4] % 3'h5), 1'b0, seed[9:7], 1'b0, dur);
    end
    tally_and_finish();
  end
endmodule
